/* File: src/chs_serial_port.v */
`include "chs_regs.vh"

module chs_serial_port (
    input wire clk,
    input wire rstn,
    input wire sclk,
    input wire cs_n,
    input wire din,
    output reg dout,
    output reg dout_oe,
    output reg eoc_n,
    input wire dac_load_n,
    input wire dac_powerup_level_sel,
    input wire [1:0] clock_mode_select,
    input wire result_valid,
    output wire result_ready,
    input wire [15:0] result_data,
    output reg cmd_valid,
    output reg [7:0] cmd_data,
    input wire dac_wr_valid,
    input wire [2:0] dac_wr_chan,
    input wire [11:0] dac_wr_data,
    output reg dac_init_done,
    output reg [95:0] dac_level
);

// synchroniser stages for every pin-side input
reg [`CHS_SYNC_BITS-1:0] sync1;
reg [`CHS_SYNC_BITS-1:0] sync2;
reg sclk_d;
reg cs_d;

wire sclk_s;
wire cs_s;
wire din_s;
wire load_s;
wire strap_s;
wire [1:0] mode_s;
wire cs_active;
wire frame_start;
wire sclk_fall;
wire sclk_rise;
wire launch_edge;
wire load_word;

// transmit side
reg [15:0] tx_shift;
reg [3:0] tx_cnt;

// receive side
reg [7:0] rx_shift;
reg [2:0] rx_cnt;

// result buffer
wire buf_valid;
wire [15:0] buf_data;

// dac input registers and strap capture
reg [11:0] dac_in [0:`CHS_DAC_CHANS-1];
reg [1:0] init_cnt;
integer i;

// two flops per pin; only the second stage feeds any logic
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        sync1 <= `CHS_SYNC_RST;
        sync2 <= `CHS_SYNC_RST;
    end else begin
        sync1 <= {clock_mode_select, dac_powerup_level_sel, dac_load_n, din, cs_n, sclk};
        sync2 <= sync1;
    end
end

assign sclk_s = sync2[`CHS_SY_SCLK];
assign cs_s = sync2[`CHS_SY_CS];
assign din_s = sync2[`CHS_SY_DIN];
assign load_s = sync2[`CHS_SY_LOAD];
assign strap_s = sync2[`CHS_SY_STRAP];
assign mode_s = sync2[`CHS_SY_MODE_HI:`CHS_SY_MODE_LO];

// delayed copies for edge detection, taken from the second stage
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        sclk_d <= 1'b0;
        cs_d <= 1'b1;
    end else begin
        sclk_d <= sclk_s;
        cs_d <= cs_s;
    end
end

// the serial clock is only oversampled; edges closer than one clk period can be lost
assign cs_active = ~cs_s;
assign frame_start = cs_active & cs_d;
assign sclk_fall = cs_active & sclk_d & ~sclk_s;
assign sclk_rise = cs_active & ~sclk_d & sclk_s;
assign launch_edge = (mode_s == `CHS_MODE_RISE) ? sclk_rise : sclk_fall;

// a word leaves the buffer at frame start and after the last bit of each word
assign load_word = frame_start | (launch_edge & (tx_cnt == `CHS_TX_LAST));

// results waiting for the host; a slow host stalls the converter side
chs_fifo2 #(
    .WIDTH(`CHS_WORD_BITS)
) u_result_buf (
    .clk(clk),
    .rstn(rstn),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .in_data(result_data),
    .out_valid(buf_valid),
    .out_ready(load_word),
    .out_data(buf_data)
);

// output shifter; an empty buffer sends zeros rather than stale data
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        tx_shift <= `CHS_WORD_RST;
        tx_cnt <= 4'h0;
        dout <= 1'b0;
    end else if (!cs_active) begin
        tx_cnt <= 4'h0;
        dout <= 1'b0;
    end else if (load_word) begin
        tx_shift <= buf_valid ? buf_data : `CHS_WORD_RST;
        dout <= buf_valid ? buf_data[15] : 1'b0;
        tx_cnt <= 4'h0;
    end else if (launch_edge) begin
        tx_shift <= {tx_shift[14:0], 1'b0};
        dout <= tx_shift[14];
        tx_cnt <= tx_cnt + 4'h1;
    end
end

// drive the data pin only inside a frame
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        dout_oe <= 1'b0;
    end else begin
        dout_oe <= cs_active;
    end
end

// end of conversion tracks a waiting result; it rises only as the last one is taken
// a pop from a full buffer, or a pop met by a push, still leaves a word waiting
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        eoc_n <= 1'b1;
    end else begin
        eoc_n <= ~(buf_valid & (~load_word | ~result_ready | result_valid));
    end
end

// input shifter, msb first, bytes handed out as one-cycle pulses
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        rx_shift <= `CHS_CMD_RST;
        rx_cnt <= 3'h0;
        cmd_valid <= 1'b0;
        cmd_data <= `CHS_CMD_RST;
    end else begin
        cmd_valid <= 1'b0;
        if (!cs_active) begin
            rx_cnt <= 3'h0;
        end else if (sclk_fall) begin
            rx_shift <= {rx_shift[6:0], din_s};
            rx_cnt <= rx_cnt + 3'h1;
            if (rx_cnt == `CHS_RX_LAST) begin
                cmd_valid <= 1'b1;
                cmd_data <= {rx_shift[6:0], din_s};
            end
        end
    end
end

// strap is read a few cycles after reset release, once its synchroniser holds it
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        init_cnt <= 2'h0;
        dac_init_done <= 1'b0;
    end else if (!dac_init_done) begin
        init_cnt <= init_cnt + 2'h1;
        if (init_cnt == `CHS_INIT_CYCLES) begin
            dac_init_done <= 1'b1;
        end
    end
end

// input registers: strap level at start-up, then user writes
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        for (i = 0; i < `CHS_DAC_CHANS; i = i + 1) begin
            dac_in[i] <= `CHS_DAC_INIT_LOW;
        end
    end else if (!dac_init_done) begin
        if (init_cnt == `CHS_INIT_CYCLES) begin
            for (i = 0; i < `CHS_DAC_CHANS; i = i + 1) begin
                dac_in[i] <= strap_s ? `CHS_DAC_INIT_HIGH : `CHS_DAC_INIT_LOW;
            end
        end
    end else if (dac_wr_valid) begin
        dac_in[dac_wr_chan] <= dac_wr_data;
    end
end

// dac registers are transparent while load is low, hold while high
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        dac_level <= {`CHS_DAC_CHANS{`CHS_DAC_INIT_LOW}};
    end else if (!load_s) begin
        for (i = 0; i < `CHS_DAC_CHANS; i = i + 1) begin
            dac_level[i*12 +: 12] <= dac_in[i];
        end
    end
end

endmodule

/* File: src/chs_regs.vh */
`ifndef CHS_REGS_VH
`define CHS_REGS_VH

// widths of the serial words and of the dac path
`define CHS_WORD_BITS 16
`define CHS_CMD_BITS 8
`define CHS_DAC_BITS 12
`define CHS_DAC_CHANS 8
`define CHS_DAC_FLAT 96
`define CHS_SYNC_BITS 7

// bit positions inside the synchroniser vector
`define CHS_SY_SCLK 0
`define CHS_SY_CS 1
`define CHS_SY_DIN 2
`define CHS_SY_LOAD 3
`define CHS_SY_STRAP 4
`define CHS_SY_MODE_LO 5
`define CHS_SY_MODE_HI 6

// reset values: chip select and dac load idle high
`define CHS_SYNC_RST 7'h0a
`define CHS_DAC_INIT_HIGH 12'hfff
`define CHS_DAC_INIT_LOW 12'h000
`define CHS_WORD_RST 16'h0000
`define CHS_CMD_RST 8'h00

// clock mode that launches output bits on the rising edge
`define CHS_MODE_RISE 2'h3

// counts
`define CHS_TX_LAST 4'hf
`define CHS_RX_LAST 3'h7
`define CHS_INIT_CYCLES 2'h3

`endif

/* File: src/chs_fifo2.v */
`include "chs_regs.vh"

// two-entry buffer; head entry always sits in slot 0
module chs_fifo2 #(
    parameter WIDTH = 16
) (
    input wire clk,
    input wire rstn,
    input wire in_valid,
    output reg in_ready,
    input wire [WIDTH-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] slot1;
reg [1:0] count;
reg [1:0] next_count;
wire wr;
wire rd;

assign wr = in_valid & in_ready;
assign rd = out_valid & out_ready;

// occupancy after this cycle's push and pop
always @* begin
    next_count = count;
    if (wr && !rd) begin
        next_count = count + 2'h1;
    end else if (rd && !wr) begin
        next_count = count - 2'h1;
    end
end

// flags are registered so the ports come straight from flip-flops
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        count <= 2'h0;
        in_ready <= 1'b1;
        out_valid <= 1'b0;
        out_data <= {WIDTH{1'b0}};
        slot1 <= {WIDTH{1'b0}};
    end else begin
        count <= next_count;
        in_ready <= (next_count != 2'h2);
        out_valid <= (next_count != 2'h0);
        if (rd && count == 2'h2) begin
            out_data <= slot1;
        end
        // a push lands behind whatever is left after the pop
        if (wr) begin
            if ((count == 2'h0) || (count == 2'h1 && rd)) begin
                out_data <= in_data;
            end else begin
                slot1 <= in_data;
            end
        end
    end
end

endmodule

/* File: bench/chs_serial_props.sv */
module chs_serial_props (
    input logic clk,
    input logic rstn,
    input logic sclk,
    input logic cs_n,
    input logic dout,
    input logic dout_oe,
    input logic eoc_n,
    input logic [1:0] clock_mode_select,
    input logic result_valid,
    input logic result_ready,
    input logic cmd_valid,
    input logic dac_load_n,
    input logic [95:0] dac_level
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // a new bit on a driven line, split by the mode that must cause it
    sequence s_fall_shift;
        $changed(dout) && dout_oe && $past(dout_oe) && clock_mode_select != 2'h3;
    endsequence
    sequence s_rise_shift;
        $changed(dout) && dout_oe && $past(dout_oe) && clock_mode_select == 2'h3;
    endsequence
    a_oe_idle: assert property (cs_n [*4] |-> !dout_oe)
        else $error("dout driven while idle");
    a_oe_frame: assert property (!cs_n [*5] |-> dout_oe)
        else $error("dout not driven in frame");
    a_byte_in_frame: assert property (cmd_valid |-> !$past(cs_n, 4))
        else $error("byte taken while idle");
    a_shift_fall: assert property (s_fall_shift |-> $past(sclk, 5) && !$past(sclk, 3))
        else $error("bit not launched on falling edge");
    a_shift_rise: assert property (s_rise_shift |-> !$past(sclk, 5) && $past(sclk, 3))
        else $error("bit not launched on rising edge");
    a_eoc_push: assert property (result_valid && result_ready |-> ##2 !eoc_n)
        else $error("eoc late after result");
    a_full_eoc: assert property (!result_ready |-> !eoc_n)
        else $error("full buffer but eoc high");
    a_dac_hold: assert property (dac_load_n [*4] |-> $stable(dac_level))
        else $error("dac moved while load high");
endmodule

/* File: bench/chs_host_model.sv */
module chs_host_model (
    input logic clk,
    input logic dout,
    input logic [1:0] mode,
    output logic sclk,
    output logic cs_n,
    output logic din
);
    timeunit 1ns;
    timeprecision 1ns;
    // host owns the clock; it is put at the mode's idle level before each frame
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // wiggles clock and data with chip select high
    task automatic noise();
        repeat (32) begin
            sclk = ~sclk;
            din = ~din;
            repeat (3) @(negedge clk);
        end
    endtask
    // half periods of 6 and 7 clk keep far under the clock ceiling
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [31:0] rx);
        @(negedge clk);
        sclk = (mode == 2'h3);
        repeat (6) @(negedge clk);
        cs_n = 1'b0;
        repeat (8) @(negedge clk);
        for (int i = 0; i < nbits; i++) begin
            din = tx[7 - i % 8];
            @(negedge clk);
            sclk = ~sclk;
            rx = {rx[30:0], dout};
            repeat (6) @(negedge clk);
            sclk = ~sclk;
            repeat (6) @(negedge clk);
        end
        cs_n = 1'b1;
        din = ~din; // released line must not keep the last bit
    endtask
endmodule

/* File: bench/test_converter_host_serial_pins.sv */
module test_converter_host_serial_pins;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, eoc_n, load_n, sel, rv, rr, cmd_valid, wv, acc;
    logic dout, dout_oe, init_done;
    logic [1:0] mode;
    logic [15:0] rd, rx, w0, w1;
    logic [31:0] rw;
    logic [7:0] cmd_data, tx;
    logic [2:0] wc;
    logic [11:0] wd;
    logic [95:0] dac_level, exp_dac;
    wire sclk, cs_n, din;
    int err_total, cmp_count, cmd_seen;
    int seed = 5321;
    chs_serial_port dut (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe), .eoc_n(eoc_n), .dac_load_n(load_n), .dac_powerup_level_sel(sel),
        .clock_mode_select(mode), .result_valid(rv), .result_ready(rr), .result_data(rd),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .dac_wr_valid(wv), .dac_wr_chan(wc),
        .dac_wr_data(wd), .dac_init_done(init_done), .dac_level(dac_level));
    chs_host_model host (.clk(clk), .dout(dout), .mode(mode), .sclk(sclk), .cs_n(cs_n), .din(din));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // counts received bytes
    always @(posedge clk) if (cmd_valid === 1'b1) cmd_seen++;
    task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic do_reset(input logic s);
        sel = s;
        rstn = 1'b0;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (10) @(negedge clk);
    endtask
    // ready is a register, so its value before the edge is the one that decides
    task automatic push(input logic [15:0] d);
        rv = 1'b1;
        rd = d;
        acc = rr;
        @(negedge clk);
    endtask
    function automatic logic [95:0] put(input logic [95:0] v, input logic [2:0] c, input logic [11:0] d);
        put = v;
        put[c * 12 +: 12] = d;
    endfunction
    // hang guard, far beyond the expected run
    initial begin
        #(50 * 20000);
        err_total++;
        wrap_up();
    end
    initial begin
        {rv, rd, wv, wc, wd, mode} = '0;
        rstn = 1'b0;
        load_n = 1'b0;
        @(negedge clk);
        do_reset(1'b1);
        chk(dac_level, {8{12'hfff}}, "strap high");
        do_reset(1'b0);
        chk(dac_level, '0, "strap low");
        $display("strap test done");
        load_n = 1'b1;
        // let the load pin pass its synchroniser before the first write
        repeat (3) @(negedge clk);
        exp_dac = '0;
        for (int i = 0; i < 8; i++) begin
            rx = 16'($random(seed));
            {wv, wc, wd} = {1'b1, rx[14:0]};
            @(negedge clk);
            wv = 1'b0;
            exp_dac = put(exp_dac, rx[14:12], rx[11:0]);
            if (i == 3) load_n = 1'b0;
            repeat (5) @(negedge clk);
            chk(dac_level, i < 3 ? 96'h0 : exp_dac, "dac");
        end
        $display("dac test done");
        for (int m = 0; m < 4; m++) begin
            mode = m[1:0];
            w0 = 16'($random(seed));
            w1 = m == 0 ? 16'hffff : 16'($random(seed));
            push(w0);
            push(w1);
            push(16'h5a5a);
            rv = 1'b0;
            chk(96'(acc), '0, "full not refused");
            chk(96'(eoc_n), '0, "eoc");
            cmd_seen = 0;
            tx = 8'($random(seed));
            // the next word follows after sixteen launch edges in one long frame
            host.xfer(tx, 32, rw);
            chk(96'(rw[31:16]), 96'(w0), "word0");
            chk(96'(rw[15:0]), 96'(w1), "word1");
            chk(96'(cmd_data), 96'(tx), "byte");
            chk(96'(eoc_n), 96'h1, "eoc");
            host.xfer(~tx, 16, rw);
            chk(96'(rw[15:0]), '0, "empty");
            chk(96'(cmd_data), {88'h0, ~tx}, "byte2");
            chk(96'(cmd_seen), 96'h6, "count");
            host.noise();
            chk(96'(cmd_seen), 96'h6, "idle noise");
            $display("mode %0d test done", m);
        end
        wrap_up();
    end
endmodule
bind chs_serial_port chs_serial_props chk_i (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .dout(dout), .dout_oe(dout_oe), .eoc_n(eoc_n), .clock_mode_select(clock_mode_select),
    .result_valid(result_valid), .result_ready(result_ready), .cmd_valid(cmd_valid),
    .dac_load_n(dac_load_n), .dac_level(dac_level));
